// [logic/hbt_params.svh]
`ifndef HBT_PARAMS_SVH
`define HBT_PARAMS_SVH

// register indices on the serial register port
`define HBT_ADDR_W            7
`define HBT_IDX_INIT_CHARGE   7'h1a
`define HBT_IDX_TURN_ON       7'h1b
`define HBT_IDX_TURN_OFF      7'h1c

// field positions
`define HBT_PDIS_MSB          15
`define HBT_PDIS_LSB          10
`define HBT_PCHG_MSB          9
`define HBT_PCHG_LSB          4
`define HBT_DLY_MSB           13
`define HBT_DLY_LSB           8
`define HBT_SEL_MSB           2
`define HBT_SEL_LSB           0

// reset values
`define HBT_RST_INIT_CHARGE   16'h3cd0
`define HBT_RST_TURN_ON       16'h0c00
`define HBT_RST_TURN_OFF      16'h0c00
`define HBT_RST_PDIS          6'h0f
`define HBT_RST_PCHG          6'h0d
`define HBT_RST_DLY           6'h0c
`define HBT_RST_SEL           3'h0

// selector codes
`define HBT_SEL_HB1           3'h0
`define HBT_SEL_HB2           3'h1
`define HBT_SEL_HB3           3'h2

// nominal delay step per code count, in picoseconds
`define HBT_DLY_STEP_PS       53300

`endif

// [logic/hbt_pkg.sv]
package hbt_pkg;

  localparam int HBT_NUM_HB = 3;

  typedef logic [5:0]  hbt_code_t;
  typedef logic [2:0]  hbt_sel_t;
  typedef logic [15:0] hbt_word_t;
  typedef logic [6:0]  hbt_addr_t;

  typedef struct packed {
    hbt_code_t [HBT_NUM_HB-1:0] pdis;
    hbt_code_t [HBT_NUM_HB-1:0] pchg;
    hbt_code_t [HBT_NUM_HB-1:0] ton;
    hbt_code_t [HBT_NUM_HB-1:0] toff;
    hbt_sel_t                   init_sel;
    hbt_sel_t                   on_sel;
    hbt_sel_t                   off_sel;
    hbt_word_t                  rdata;
    logic                       rvalid;
    logic                       err;
  } hbt_state_t;

endpackage

// [logic/hbt_bank.sv]
`timescale 1ns/10ps
`include "hbt_params.svh"
// What this block does
// - init selector 000/001/010 picks bridge one-three
// - predischarge code bits 15:10, default 001111
// - precharge code bits 9:4, default 001101
// - init register bit 3 reads zero
// - turn-on code bits 13:8, default 12
// - turn-on selector 000/001/010 picks bridge
// - turn-off code bits 13:8, default 12
// - turn-off selector 000/001/010 picks bridge
// - delay registers bits 15:14, 7:3 read zero
module hbt_bank (
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_en_i,
  input  wire logic              soft_rst_i,
  input  wire logic              restart_i,
  input  wire hbt_pkg::hbt_addr_t reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire hbt_pkg::hbt_word_t reg_wdata_i,
  output logic                   reg_rvalid_o,
  output hbt_pkg::hbt_word_t     reg_rdata_o,
  output logic                   reg_err_o,
  output hbt_pkg::hbt_code_t     hb1_predischarge_o,
  output hbt_pkg::hbt_code_t     hb2_predischarge_o,
  output hbt_pkg::hbt_code_t     hb3_predischarge_o,
  output hbt_pkg::hbt_code_t     hb1_precharge_o,
  output hbt_pkg::hbt_code_t     hb2_precharge_o,
  output hbt_pkg::hbt_code_t     hb3_precharge_o,
  output hbt_pkg::hbt_code_t     hb1_turn_on_o,
  output hbt_pkg::hbt_code_t     hb2_turn_on_o,
  output hbt_pkg::hbt_code_t     hb3_turn_on_o,
  output hbt_pkg::hbt_code_t     hb1_turn_off_o,
  output hbt_pkg::hbt_code_t     hb2_turn_off_o,
  output hbt_pkg::hbt_code_t     hb3_turn_off_o
);
  import hbt_pkg::*;

  hbt_state_t st_q;
  hbt_state_t st_d;
  hbt_code_t  pdis_w [HBT_NUM_HB];
  hbt_code_t  pchg_w [HBT_NUM_HB];
  hbt_code_t  ton_w  [HBT_NUM_HB];
  hbt_code_t  toff_w [HBT_NUM_HB];
  hbt_sel_t   wsel_w;
  hbt_word_t  init_img_w;
  hbt_word_t  on_img_w;
  hbt_word_t  off_img_w;
  logic [HBT_NUM_HB-1:0] init_we_w;
  logic [HBT_NUM_HB-1:0] on_we_w;
  logic [HBT_NUM_HB-1:0] off_we_w;

  // selector names a real bridge
  function automatic logic sel_ok(input hbt_sel_t sel);
    sel_ok = (sel == `HBT_SEL_HB1) || (sel == `HBT_SEL_HB2)
          || (sel == `HBT_SEL_HB3);
  endfunction

  // selector to bridge index
  function automatic logic [1:0] sel_idx(input hbt_sel_t sel);
    sel_idx = sel[1:0];
  endfunction

  // selector names bridge idx
  function automatic logic bank_hit(input hbt_sel_t sel, input int idx);
    bank_hit = sel_ok(sel) && (sel_idx(sel) == idx[1:0]);
  endfunction

  // field pickers for write data
  function automatic hbt_sel_t sel_field(input hbt_word_t w);
    sel_field = w[`HBT_SEL_MSB:`HBT_SEL_LSB];
  endfunction

  function automatic hbt_code_t pdis_field(input hbt_word_t w);
    pdis_field = w[`HBT_PDIS_MSB:`HBT_PDIS_LSB];
  endfunction

  function automatic hbt_code_t pchg_field(input hbt_word_t w);
    pchg_field = w[`HBT_PCHG_MSB:`HBT_PCHG_LSB];
  endfunction

  function automatic hbt_code_t dly_field(input hbt_word_t w);
    dly_field = w[`HBT_DLY_MSB:`HBT_DLY_LSB];
  endfunction

  // stored code of the selected bridge, zero for an invalid selector
  function automatic hbt_code_t bank_code(input hbt_code_t [HBT_NUM_HB-1:0] codes,
                                          input hbt_sel_t                   sel);
    bank_code = '0;
    for (int i = 0; i < HBT_NUM_HB; i++)
    begin
      if (bank_hit(sel, i))
      begin
        bank_code = codes[i];
      end
    end
  endfunction

  // index names one of the three registers
  function automatic logic reg_mapped(input hbt_addr_t addr);
    reg_mapped = (addr == `HBT_IDX_INIT_CHARGE) || (addr == `HBT_IDX_TURN_ON)
              || (addr == `HBT_IDX_TURN_OFF);
  endfunction

  // error flag of a taken access
  function automatic logic acc_err(input logic      wr,
                                   input hbt_addr_t addr,
                                   input hbt_sel_t  sel);
    acc_err = !reg_mapped(addr) || (wr && !sel_ok(sel));
  endfunction

  // init register read image, bit 3 held at zero
  function automatic hbt_word_t init_word(input hbt_code_t pdis,
                                          input hbt_code_t pchg,
                                          input hbt_sel_t  sel);
    hbt_word_t w;
    w                              = '0;
    w[`HBT_PDIS_MSB:`HBT_PDIS_LSB] = pdis;
    w[`HBT_PCHG_MSB:`HBT_PCHG_LSB] = pchg;
    w[`HBT_SEL_MSB:`HBT_SEL_LSB]   = sel;
    init_word                      = w;
  endfunction

  // delay register read image, reserved bits held at zero
  function automatic hbt_word_t dly_word(input hbt_code_t code, input hbt_sel_t sel);
    hbt_word_t w;
    w                            = '0;
    w[`HBT_DLY_MSB:`HBT_DLY_LSB] = code;
    w[`HBT_SEL_MSB:`HBT_SEL_LSB] = sel;
    dly_word                     = w;
  endfunction

  // restart image: selectors cleared, stored codes kept
  function automatic hbt_state_t restart_state(input hbt_state_t s);
    hbt_state_t r;
    r             = s;
    r.init_sel    = `HBT_RST_SEL;
    r.on_sel      = `HBT_RST_SEL;
    r.off_sel     = `HBT_RST_SEL;
    r.rvalid      = 1'b0;
    restart_state = r;
  endfunction

  // por / soft reset image
  function automatic hbt_state_t por_state();
    hbt_state_t s;
    s        = '0;
    for (int i = 0; i < HBT_NUM_HB; i++)
    begin
      s.pdis[i] = `HBT_RST_PDIS;
      s.pchg[i] = `HBT_RST_PCHG;
      s.ton[i]  = `HBT_RST_DLY;
      s.toff[i] = `HBT_RST_DLY;
    end
    s.init_sel = `HBT_RST_SEL;
    s.on_sel   = `HBT_RST_SEL;
    s.off_sel  = `HBT_RST_SEL;
    por_state  = s;
  endfunction

  always_comb
  begin
    hbt_word_t rd;
    rd          = '0;
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    if (soft_rst_i)
    begin
      st_d = por_state();
    end
    else if (restart_i)
    begin
      st_d = restart_state(st_q);
    end
    else if (reg_wr_i)
    begin
      st_d.err = acc_err(1'b1, reg_addr_i, wsel_w);
      unique case (reg_addr_i)
        `HBT_IDX_INIT_CHARGE:
        begin
          st_d.init_sel = wsel_w;
          for (int i = 0; i < HBT_NUM_HB; i++)
          begin
            if (init_we_w[i])
            begin
              st_d.pdis[i] = pdis_field(reg_wdata_i);
              st_d.pchg[i] = pchg_field(reg_wdata_i);
            end
          end
        end

        `HBT_IDX_TURN_ON:
        begin
          st_d.on_sel = wsel_w;
          for (int i = 0; i < HBT_NUM_HB; i++)
          begin
            if (on_we_w[i])
            begin
              st_d.ton[i] = dly_field(reg_wdata_i);
            end
          end
        end

        `HBT_IDX_TURN_OFF:
        begin
          st_d.off_sel = wsel_w;
          for (int i = 0; i < HBT_NUM_HB; i++)
          begin
            if (off_we_w[i])
            begin
              st_d.toff[i] = dly_field(reg_wdata_i);
            end
          end
        end

        default:
        begin
          // unmapped index stores nothing
        end
      endcase
    end
    else if (reg_rd_i)
    begin
      st_d.rvalid = 1'b1;
      st_d.err    = acc_err(1'b0, reg_addr_i, wsel_w);
      unique case (reg_addr_i)
        `HBT_IDX_INIT_CHARGE:
        begin
          rd = init_img_w;
        end

        `HBT_IDX_TURN_ON:
        begin
          rd = on_img_w;
        end

        `HBT_IDX_TURN_OFF:
        begin
          rd = off_img_w;
        end

        default:
        begin
          rd = '0;
        end
      endcase
      st_d.rdata = rd;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= por_state();
    end
    else if (clk_en_i)
    begin
      st_q <= st_d;
    end
  end

  // per-bridge views of stored codes
  for (genvar g = 0; g < HBT_NUM_HB; g++)
  begin : g_hb
    assign pdis_w[g] = st_q.pdis[g];
    assign pchg_w[g] = st_q.pchg[g];
    assign ton_w[g]  = st_q.ton[g];
    assign toff_w[g] = st_q.toff[g];
  end

  // per-bridge write enables from the write selector
  assign wsel_w = sel_field(reg_wdata_i);
  for (genvar g = 0; g < HBT_NUM_HB; g++)
  begin : g_we
    assign init_we_w[g] = (reg_addr_i == `HBT_IDX_INIT_CHARGE)
                       && bank_hit(wsel_w, g);
    assign on_we_w[g]   = (reg_addr_i == `HBT_IDX_TURN_ON)
                       && bank_hit(wsel_w, g);
    assign off_we_w[g]  = (reg_addr_i == `HBT_IDX_TURN_OFF)
                       && bank_hit(wsel_w, g);
  end

  // read images of the three registers for the stored selectors
  assign init_img_w = init_word(bank_code(st_q.pdis, st_q.init_sel),
                                bank_code(st_q.pchg, st_q.init_sel),
                                st_q.init_sel);
  assign on_img_w   = dly_word(bank_code(st_q.ton, st_q.on_sel), st_q.on_sel);
  assign off_img_w  = dly_word(bank_code(st_q.toff, st_q.off_sel), st_q.off_sel);

  assign reg_rvalid_o       = st_q.rvalid;
  assign reg_rdata_o        = st_q.rdata;
  assign reg_err_o          = st_q.err;
  assign hb1_predischarge_o = pdis_w[0];
  assign hb2_predischarge_o = pdis_w[1];
  assign hb3_predischarge_o = pdis_w[2];
  assign hb1_precharge_o    = pchg_w[0];
  assign hb2_precharge_o    = pchg_w[1];
  assign hb3_precharge_o    = pchg_w[2];
  assign hb1_turn_on_o      = ton_w[0];
  assign hb2_turn_on_o      = ton_w[1];
  assign hb3_turn_on_o      = ton_w[2];
  assign hb1_turn_off_o     = toff_w[0];
  assign hb2_turn_off_o     = toff_w[1];
  assign hb3_turn_off_o     = toff_w[2];

endmodule

// [test/hbt_bank_assertions.sv]
`timescale 1ns/10ps
module hbt_bank_assertions
  import hbt_pkg::*;
(
  input wire logic      sys_clk_i,
  input wire logic      sys_rst_i,
  input wire logic      clk_en_i,
  input wire logic      soft_rst_i,
  input wire logic      restart_i,
  input wire hbt_addr_t reg_addr_i,
  input wire logic      reg_wr_i,
  input wire logic      reg_rd_i,
  input wire hbt_word_t reg_wdata_i,
  input wire logic      reg_rvalid_o,
  input wire hbt_word_t reg_rdata_o,
  input wire logic      reg_err_o,
  input wire hbt_code_t hb1_predischarge_o,
  input wire hbt_code_t hb2_turn_on_o,
  input wire hbt_code_t hb3_turn_off_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic tk;
  logic tw;
  assign tk = clk_en_i && !soft_rst_i && !restart_i;
  assign tw = tk && reg_wr_i;
  // index of the last taken read
  hbt_addr_t ra_q;
  always_ff @(posedge sys_clk_i)
  begin
    if (tk && reg_rd_i && !reg_wr_i)
    begin
      ra_q <= reg_addr_i;
    end
  end
  chk_read_answer: assert property (tk && reg_rd_i && !reg_wr_i |=> reg_rvalid_o)
    else $error("read not answered");
  chk_no_stray: assert property (clk_en_i && !(tk && reg_rd_i && !reg_wr_i)
    |=> !reg_rvalid_o)
    else $error("stray read valid");
  chk_bad_sel: assert property (tw && (reg_wdata_i[2:0] > 3'h2) |=> reg_err_o)
    else $error("bad selector not flagged");
  chk_unmapped_err: assert property (tk && (reg_wr_i || reg_rd_i)
    && !(reg_addr_i inside {7'h1a, 7'h1b, 7'h1c}) |=> reg_err_o)
    else $error("unmapped access not flagged");
  chk_pdis_route: assert property (tw && reg_addr_i == 7'h1a && reg_wdata_i[2:0] == 3'h0
    |=> hb1_predischarge_o == $past(reg_wdata_i[15:10]))
    else $error("bridge one predischarge not stored");
  chk_on_route: assert property (tw && reg_addr_i == 7'h1b && reg_wdata_i[2:0] == 3'h1
    |=> hb2_turn_on_o == $past(reg_wdata_i[13:8]))
    else $error("bridge two turn-on not stored");
  chk_off_route: assert property (tw && reg_addr_i == 7'h1c && reg_wdata_i[2:0] == 3'h2
    |=> hb3_turn_off_o == $past(reg_wdata_i[13:8]))
    else $error("bridge three turn-off not stored");
  chk_init_rsv: assert property (reg_rvalid_o && ra_q == 7'h1a
    |-> !reg_rdata_o[3])
    else $error("init bit 3 not zero");
  chk_dly_rsv: assert property (reg_rvalid_o && ra_q != 7'h1a
    |-> reg_rdata_o[15:14] == 2'h0 && reg_rdata_o[7:3] == 5'h0)
    else $error("delay reserved bits not zero");
  cov_bad_write: cover property (tw && reg_wdata_i[2]);
  cov_read: cover property (reg_rvalid_o);
  cov_restart: cover property (restart_i);
endmodule
bind hbt_bank hbt_bank_assertions CHK (.*);

// [test/hbt_host.sv]
`timescale 1ns/10ps
module hbt_host
  import hbt_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rvalid_i,
  input  wire hbt_word_t rdata_i,
  output hbt_addr_t      addr_o,
  output logic           wr_o,
  output logic           rd_o,
  output hbt_word_t      wdata_o
);
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = '0;
    wdata_o = '0;
  end
  // idle data is inverted so a stale value never passes
  task automatic wr(input hbt_addr_t a, input hbt_word_t d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd(input hbt_addr_t a, output hbt_word_t d, output logic v);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    v = rvalid_i;
    d = rdata_i;
    rd_o = 1'b0;
  endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import hbt_pkg::*;
  logic      sys_clk_i, sys_rst_i, clk_en_i, soft_rst_i, restart_i;
  logic      wr, rd, rvalid, err;
  hbt_addr_t addr;
  hbt_word_t wdata, rdata;
  hbt_code_t pd[3], pc[3], on[3], off[3];
  hbt_sel_t  bad[3] = '{3'h3, 3'h4, 3'h7};
  int        failures, tests_run;
  hbt_bank DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .soft_rst_i(soft_rst_i), .restart_i(restart_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rvalid_o(rvalid), .reg_rdata_o(rdata),
    .reg_err_o(err), .hb1_predischarge_o(pd[0]), .hb2_predischarge_o(pd[1]),
    .hb3_predischarge_o(pd[2]), .hb1_precharge_o(pc[0]), .hb2_precharge_o(pc[1]),
    .hb3_precharge_o(pc[2]), .hb1_turn_on_o(on[0]), .hb2_turn_on_o(on[1]),
    .hb3_turn_on_o(on[2]), .hb1_turn_off_o(off[0]), .hb2_turn_off_o(off[1]),
    .hb3_turn_off_o(off[2]));
  hbt_host HOST (.clk_i(sys_clk_i), .rvalid_i(rvalid), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input hbt_addr_t a, input hbt_word_t e);
    hbt_word_t d;
    logic      v;
    HOST.rd(a, d, v);
    chk("rvalid", 16'h1, {15'h0, v});
    chk("rdata", e, d);
  endtask
  task automatic outs();
    for (int k = 0; k < 3; k++)
    begin
      chk("pdis", 16'(k + 33), {10'h0, pd[k]});
      chk("pchg", 16'(k + 20), {10'h0, pc[k]});
      chk("ton", 16'(k + 40), {10'h0, on[k]});
      chk("toff", 16'(k + 40), {10'h0, off[k]});
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    failures++;
    final_report();
  end
  initial
  begin
    failures = 0;
    tests_run = 0;
    {sys_rst_i, clk_en_i, soft_rst_i, restart_i} = 4'b1100;
    repeat (10) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    chk("pdis rst", 16'h0f, {10'h0, pd[2]});
    chk("ton rst", 16'h0c, {10'h0, on[1]});
    rchk(7'h1a, 16'h3cd0);
    rchk(7'h1b, 16'h0c00);
    rchk(7'h1c, 16'h0c00);
    for (int k = 0; k < 3; k++)
    begin
      HOST.wr(7'h1a, {6'(k + 33), 6'(k + 20), 4'h8 | 4'(k)});
      rchk(7'h1a, {6'(k + 33), 6'(k + 20), 4'(k)});
      HOST.wr(7'h1b, {2'h3, 6'(k + 40), 8'hf8 | 8'(k)});
      rchk(7'h1b, {2'h0, 6'(k + 40), 8'(k)});
      HOST.wr(7'h1c, {2'h3, 6'(k + 40), 8'hf8 | 8'(k)});
      rchk(7'h1c, {2'h0, 6'(k + 40), 8'(k)});
    end
    outs();
    foreach (bad[i])
    begin
      HOST.wr(7'h1a + 7'(i), {10'h001, 3'h0, bad[i]});
      chk("err", 16'h1, {15'h0, err});
    end
    outs();
    rchk(7'h1b, 16'h0004);
    rchk(7'h1d, 16'h0000);
    chk("err map", 16'h1, {15'h0, err});
    @(negedge sys_clk_i);
    restart_i = 1'b1;
    @(negedge sys_clk_i);
    restart_i = 1'b0;
    rchk(7'h1c, {2'h0, 6'd40, 8'h0});
    chk("err ok", 16'h0, {15'h0, err});
    soft_rst_i = 1'b1;
    @(negedge sys_clk_i);
    soft_rst_i = 1'b0;
    chk("pchg soft", 16'h0d, {10'h0, pc[2]});
    rchk(7'h1a, 16'h3cd0);
    clk_en_i = 1'b0;
    HOST.wr(7'h1b, 16'h3f00);
    chk("ton frz", 16'h0c, {10'h0, on[0]});
    chk("rvalid frz", 16'h1, {15'h0, rvalid});
    clk_en_i = 1'b1;
    final_report();
  end
endmodule
